/* verilog/htiming_pkg.sv */
// constants for the horizontal character timing block
package htiming_pkg;
    // host i/o ports, mono and colour ranges, sequencer pair
    localparam logic [9:0] MONO_INDEX_PORT = 10'h3b4;
    localparam logic [9:0] MONO_DATA_PORT = 10'h3b5;
    localparam logic [9:0] COLOR_INDEX_PORT = 10'h3d4;
    localparam logic [9:0] COLOR_DATA_PORT = 10'h3d5;
    localparam logic [9:0] SEQ_INDEX_PORT = 10'h3c4;
    localparam logic [9:0] SEQ_DATA_PORT = 10'h3c5;
    // timing data register indices
    localparam logic [5:0] IDX_TOTAL = 6'h00;
    localparam logic [5:0] IDX_DISP_END = 6'h01;
    localparam logic [5:0] IDX_BLANK_START = 6'h02;
    localparam logic [5:0] IDX_BLANK_END = 6'h03;
    localparam logic [5:0] IDX_SYNC_START = 6'h04;
    localparam logic [5:0] IDX_SYNC_END = 6'h05;
    localparam logic [5:0] IDX_PROTECT_LAST = 6'h07;
    localparam logic [5:0] IDX_PEN_HIGH = 6'h10;
    localparam logic [5:0] IDX_PEN_LOW = 6'h11;
    localparam logic [5:0] IDX_ALT_BASE = 6'h28;
    localparam logic [5:0] IDX_ALT_LAST = 6'h2d;
    localparam int HREG_COUNT = 6;
    // sequencer indices
    localparam logic [2:0] SEQ_IDX_HOLD = 3'h7;
    // field positions
    localparam int SKEW_LSB = 5;
    localparam int PEN_EN_BIT = 7;
    localparam int DELAY_LSB = 5;
    localparam int BLANK_END_B5_BIT = 7;
    // counting
    localparam logic [8:0] TOTAL_EXTRA = 9'd5;
    localparam logic [3:0] DOTS_NINE_RELOAD = 4'd8;
    localparam logic [3:0] DOTS_EIGHT_RELOAD = 4'd7;
    localparam logic [7:0] HREG_RESET = 8'h00;
endpackage : htiming_pkg

/* verilog/hreg_bank.sv */
// primary and alternate horizontal timing register sets
`timescale 1ns/1ps
module hreg_bank #(
    parameter int W = 8,
    parameter int N = 6
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    // write port
    input wire logic wr_en_i,
    input wire logic wr_alt_i,
    input wire logic [2:0] wr_sel_i,
    input wire logic [W-1:0] wr_data_i,
    // set select
    input wire logic alt_mode_i,
    // register contents
    output logic [N*W-1:0] prim_o,
    output logic [N*W-1:0] alt_o,
    output logic [N*W-1:0] act_o
);
    import htiming_pkg::*;

    logic [N*W-1:0] prim_ff;
    logic [N*W-1:0] alt_ff;

    // one byte of one set is written per access
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prim_ff <= {N{HREG_RESET}};
            alt_ff <= {N{HREG_RESET}};
        end else if (wr_en_i && int'(wr_sel_i) < N) begin
            if (wr_alt_i) begin
                alt_ff[int'(wr_sel_i)*W +: W] <= wr_data_i;
            end else begin
                prim_ff[int'(wr_sel_i)*W +: W] <= wr_data_i;
            end
        end
    end

    // alternate set steers timing in the low-resolution modes
    assign prim_o = prim_ff;
    assign alt_o = alt_ff;
    assign act_o = alt_mode_i ? alt_ff : prim_ff;
endmodule : hreg_bank

/* verilog/htiming.sv */
// horizontal character timing with indexed host register port
`timescale 1ns/1ps
module htiming (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    // host i/o bus
    input wire logic [9:0] io_addr_i,
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic [7:0] io_wdata_i,
    output logic [7:0] io_rdata_o,
    // mode and protection controls
    input wire logic addr_select_i,
    input wire logic group0_protect_i,
    input wire logic extension_protect_i,
    input wire logic alt_mode_i,
    input wire logic dot_select_i,
    // vertical and pen readback sources
    input wire logic [7:0] vsync_start_or_pen_high_i,
    input wire logic [7:0] vsync_end_or_pen_low_i,
    input wire logic [7:0] pen_high_i,
    input wire logic [7:0] pen_low_i,
    // monitor side and vertical counter
    output logic hsync_o,
    output logic hblank_o,
    output logic display_enable_out_o,
    output logic line_advance_o,
    output logic line_pulse_o,
    output logic [8:0] hcount_o
);
    import htiming_pkg::*;

    // picks byte n out of a packed register set
    function automatic logic [7:0] sel_byte(input logic [47:0] v, input logic [5:0] n);
        sel_byte = v[int'(n[2:0])*8 +: 8];
    endfunction : sel_byte

    logic [5:0] index_ff;
    logic [2:0] seq_index_ff;
    logic hold_ff;
    logic [7:0] rdata_ff;
    logic [3:0] dot_cnt_ff;
    logic [8:0] cnt_ff;
    logic blank_raw_ff;
    logic sync_raw_ff;
    logic [2:0] de_pipe_ff;
    logic [2:0] sync_pipe_ff;
    logic [2:0] blank_pipe_ff;
    logic de_out_ff;
    logic sync_out_ff;
    logic blank_out_ff;
    logic de_prev_ff;
    logic line_adv_ff;
    logic line_pulse_ff;
    logic [47:0] prim;
    logic [47:0] alt;
    logic [47:0] act;

    // address decode by emulation range
    wire idx_port = io_addr_i == (addr_select_i ? COLOR_INDEX_PORT : MONO_INDEX_PORT);
    wire data_port = io_addr_i == (addr_select_i ? COLOR_DATA_PORT : MONO_DATA_PORT);
    wire seq_idx_port = io_addr_i == SEQ_INDEX_PORT;
    wire seq_data_port = io_addr_i == SEQ_DATA_PORT;
    wire protect = group0_protect_i | extension_protect_i;
    wire is_prim = index_ff < HREG_COUNT[5:0];
    wire is_alt = index_ff >= IDX_ALT_BASE && index_ff <= IDX_ALT_LAST;
    wire alt_protected = protect;
    wire prim_protected = protect && index_ff <= IDX_PROTECT_LAST;
    wire bank_we = io_wr_i && data_port &&
        ((is_prim && !prim_protected) || (is_alt && !alt_protected));
    wire [5:0] alt_off = index_ff - IDX_ALT_BASE;
    wire [2:0] bank_sel = is_alt ? alt_off[2:0] : index_ff[2:0];
    wire seq_wr = io_wr_i && seq_data_port;

    // active timing fields
    wire [7:0] total = sel_byte(act, IDX_TOTAL);
    wire [7:0] disp_end = sel_byte(act, IDX_DISP_END);
    wire [7:0] blank_start = sel_byte(act, IDX_BLANK_START);
    wire [7:0] blank_end_reg = sel_byte(act, IDX_BLANK_END);
    wire [7:0] sync_start = sel_byte(act, IDX_SYNC_START);
    wire [7:0] sync_end_reg = sel_byte(act, IDX_SYNC_END);
    wire [1:0] skew = blank_end_reg[SKEW_LSB +: 2];
    wire [1:0] delay = sync_end_reg[DELAY_LSB +: 2];
    wire pen_en = blank_end_reg[PEN_EN_BIT];
    wire [5:0] blank_end6 = {sync_end_reg[BLANK_END_B5_BIT], blank_end_reg[4:0]};
    wire [4:0] sync_end5 = sync_end_reg[4:0];

    // character tick and counter terms
    wire tick = dot_cnt_ff == 4'd0;
    wire [8:0] last = {1'b0, total} + TOTAL_EXTRA - 9'd1;
    wire at_last = cnt_ff == last;
    wire de_raw = cnt_ff <= {1'b0, disp_end};
    wire blank_hit = cnt_ff == {1'b0, blank_start};
    wire blank_done = cnt_ff[5:0] == blank_end6;
    wire sync_hit = cnt_ff == {1'b0, sync_start};
    wire sync_done = cnt_ff[4:0] == sync_end5;
    // tap n is the flag n characters late, so all four skew codes are usable
    wire [3:0] de_taps = {de_pipe_ff, de_raw};
    wire [3:0] sync_taps = {sync_pipe_ff, sync_raw_ff};
    wire [3:0] blank_taps = {blank_pipe_ff, blank_raw_ff};

    // read data selection
    wire [7:0] pen_or_vhigh = pen_en ? vsync_start_or_pen_high_i : pen_high_i;
    wire [7:0] pen_or_vlow = pen_en ? vsync_end_or_pen_low_i : pen_low_i;
    wire [7:0] data_rd = is_prim ? sel_byte(prim, index_ff) :
        is_alt ? sel_byte(alt, alt_off) :
        index_ff == IDX_PEN_HIGH ? pen_or_vhigh :
        index_ff == IDX_PEN_LOW ? pen_or_vlow : 8'h00;
    wire [7:0] seq_rd = seq_index_ff == SEQ_IDX_HOLD ? {7'h00, hold_ff} : 8'h00;
    wire [7:0] nxt_rdata = idx_port ? {2'b00, index_ff} :
        data_port ? data_rd :
        seq_idx_port ? {5'h00, seq_index_ff} :
        seq_data_port ? seq_rd : 8'h00;

    hreg_bank #(
        .W(8),
        .N(HREG_COUNT)
    ) u_bank (
        .clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i),
        .wr_en_i(bank_we),
        .wr_alt_i(is_alt),
        .wr_sel_i(bank_sel),
        .wr_data_i(io_wdata_i),
        .alt_mode_i(alt_mode_i),
        .prim_o(prim),
        .alt_o(alt),
        .act_o(act)
    );

    // index registers
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            index_ff <= 6'h00;
            seq_index_ff <= 3'h0;
        end else begin
            if (io_wr_i && idx_port) index_ff <= io_wdata_i[5:0];
            if (io_wr_i && seq_idx_port) seq_index_ff <= io_wdata_i[2:0];
        end
    end

    // counter hold latch
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hold_ff <= 1'b0;
        end else if (seq_wr) begin
            hold_ff <= seq_index_ff == SEQ_IDX_HOLD;
        end
    end

    // registered read data
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) rdata_ff <= 8'h00;
        else if (io_rd_i) rdata_ff <= nxt_rdata;
    end

    // dot divider, period chosen at each character start
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) dot_cnt_ff <= 4'd0;
        else if (tick) dot_cnt_ff <= dot_select_i ? DOTS_EIGHT_RELOAD : DOTS_NINE_RELOAD;
        else dot_cnt_ff <= dot_cnt_ff - 4'd1;
    end

    // character counter, forced to zero while held
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_ff <= 9'd0;
            line_pulse_ff <= 1'b0;
        end else begin
            line_pulse_ff <= tick && !hold_ff && at_last;
            if (hold_ff) cnt_ff <= 9'd0;
            else if (tick) cnt_ff <= at_last ? 9'd0 : cnt_ff + 9'd1;
        end
    end

    // blank and sync flags, end wins over start
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            blank_raw_ff <= 1'b0;
            sync_raw_ff <= 1'b0;
        end else if (tick) begin
            if (blank_done) blank_raw_ff <= 1'b0;
            else if (blank_hit) blank_raw_ff <= 1'b1;
            if (sync_done) sync_raw_ff <= 1'b0;
            else if (sync_hit) sync_raw_ff <= 1'b1;
        end
    end

    // skew and delay pipelines in character steps
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            de_pipe_ff <= 3'h0;
            sync_pipe_ff <= 3'h0;
            blank_pipe_ff <= 3'h0;
            de_out_ff <= 1'b0;
            sync_out_ff <= 1'b0;
            blank_out_ff <= 1'b0;
        end else if (tick) begin
            de_pipe_ff <= de_taps[2:0];
            sync_pipe_ff <= sync_taps[2:0];
            blank_pipe_ff <= blank_taps[2:0];
            de_out_ff <= de_taps[skew];
            sync_out_ff <= sync_taps[delay];
            blank_out_ff <= blank_taps[skew];
        end
    end

    // line advance on falling display enable only
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            de_prev_ff <= 1'b0;
            line_adv_ff <= 1'b0;
        end else begin
            line_adv_ff <= tick && de_prev_ff && !de_raw;
            if (tick) de_prev_ff <= de_raw;
        end
    end

    assign io_rdata_o = rdata_ff;
    assign hsync_o = sync_out_ff;
    assign hblank_o = blank_out_ff;
    assign display_enable_out_o = de_out_ff;
    assign line_advance_o = line_adv_ff;
    assign line_pulse_o = line_pulse_ff;
    assign hcount_o = cnt_ff;

    // checks
    idx_mask_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        io_wr_i && idx_port |=> index_ff == $past(io_wdata_i[5:0]))
        else $error("index not low six bits");
    range_sel_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        io_wr_i && io_addr_i == COLOR_INDEX_PORT && !addr_select_i |=> $stable(index_ff))
        else $error("colour port decoded in mono range");
    line_len_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        tick && !hold_ff && at_last |=> cnt_ff == 9'd0 && line_pulse_o)
        else $error("line did not wrap at total plus five");
    de_span_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        tick && !hold_ff && !at_last && cnt_ff == {1'b0, disp_end}
        |=> !de_raw || $changed(act))
        else $error("display enable longer than end plus one");
    blank_start_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        tick && blank_hit && !blank_done |=> blank_raw_ff)
        else $error("blank did not start");
    blank_end_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        tick && blank_done |=> !blank_raw_ff)
        else $error("blank did not end");
    de_skew_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        tick && skew == 2'd1 |=> display_enable_out_o == $past(de_pipe_ff[0]))
        else $error("display enable skew wrong");
    skew_max_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        tick && skew == 2'd3 |=> display_enable_out_o == $past(de_pipe_ff[2]))
        else $error("display enable skew of three wrong");
    pen_read_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        io_rd_i && data_port && index_ff == IDX_PEN_HIGH && !pen_en
        |=> io_rdata_o == $past(pen_high_i))
        else $error("pen register not read back");
    sync_start_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        tick && sync_hit && !sync_done |=> sync_raw_ff)
        else $error("sync did not start");
    sync_end_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        tick && sync_done |=> !sync_raw_ff)
        else $error("sync did not end");
    sync_delay_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        tick && delay == 2'd0 |=> hsync_o == $past(sync_raw_ff))
        else $error("sync delay wrong");
    hold_set_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        seq_wr && seq_index_ff == SEQ_IDX_HOLD |=> hold_ff ##1 cnt_ff == 9'd0)
        else $error("hold did not zero counter");
    hold_clr_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        seq_wr && seq_index_ff != SEQ_IDX_HOLD |=> !hold_ff)
        else $error("hold not released");
    held_line_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        hold_ff [*3] |-> !line_advance_o)
        else $error("line advanced while held");
    protect_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        io_wr_i && data_port && protect && index_ff <= IDX_PROTECT_LAST
        |=> $stable(prim))
        else $error("protected write took effect");
    char_eight_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        tick && dot_select_i |=> !tick [*7] ##1 tick)
        else $error("eight-dot character wrong length");
    char_nine_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        tick && !dot_select_i |=> !tick [*8] ##1 tick)
        else $error("nine-dot character wrong length");
endmodule : htiming

/* testbench/htiming_host.sv */
// host i/o bus model that drives the indexed register ports
`timescale 1ns/1ps
module htiming_host (
    // clock
    input wire logic clk_sys_i,
    // host i/o bus
    output logic [9:0] io_addr_o,
    output logic io_wr_o,
    output logic io_rd_o,
    output logic [7:0] io_wdata_o,
    input wire logic [7:0] io_rdata_i
);
    // bus idle at time zero
    initial begin
        io_addr_o = 10'h000;
        io_wr_o = 1'b0;
        io_rd_o = 1'b0;
        io_wdata_o = 8'h00;
    end
    // one write: strobe held across one rising edge, then released
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(negedge clk_sys_i);
        io_addr_o = a;
        io_wdata_o = d;
        io_wr_o = 1'b1;
        @(negedge clk_sys_i);
        io_wr_o = 1'b0;
        io_addr_o = ~a; // released lines show no stale value
        io_wdata_o = ~d;
    endtask : wr
    // one read: data taken on the second falling edge after the strobe edge
    task automatic rd(input logic [9:0] a, output logic [7:0] d);
        @(negedge clk_sys_i);
        io_addr_o = a;
        io_rd_o = 1'b1;
        @(negedge clk_sys_i);
        io_rd_o = 1'b0;
        io_addr_o = ~a;
        @(negedge clk_sys_i);
        d = io_rdata_i;
    endtask : rd
endmodule : htiming_host

/* testbench/test_htiming.sv */
// self-checking bench for the horizontal character timing block
`timescale 1ns/1ps
module test_htiming;
    import htiming_pkg::*;
    logic clk_sys_i = 1'b0, rstn_i = 1'b0, io_wr_i, io_rd_i;
    logic addr_select_i = 1'b1, group0_protect_i = 1'b0, extension_protect_i = 1'b0;
    logic alt_mode_i = 1'b0, dot_select_i = 1'b0;
    logic [9:0] io_addr_i;
    logic [7:0] io_wdata_i, io_rdata_o, vs_hi = 8'h00, vs_lo = 8'h00, pen_hi = 8'h00, pen_lo = 8'h00;
    logic hsync_o, hblank_o, display_enable_out_o, line_advance_o, line_pulse_o;
    logic [8:0] hcount_o;
    logic [31:0] seed = 32'hff736ea5;
    int errors = 0, num_checks = 0, cycles = 0, adv_seen = 0;
    // port pair follows the range select, read at call time
    function automatic logic [9:0] ip();
        return addr_select_i ? COLOR_INDEX_PORT : MONO_INDEX_PORT;
    endfunction : ip
    function automatic logic [9:0] dp();
        return addr_select_i ? COLOR_DATA_PORT : MONO_DATA_PORT;
    endfunction : dp
    // device and host model
    htiming i_dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .io_addr_i(io_addr_i),
        .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
        .addr_select_i(addr_select_i), .group0_protect_i(group0_protect_i),
        .extension_protect_i(extension_protect_i), .alt_mode_i(alt_mode_i),
        .dot_select_i(dot_select_i), .vsync_start_or_pen_high_i(vs_hi),
        .vsync_end_or_pen_low_i(vs_lo), .pen_high_i(pen_hi), .pen_low_i(pen_lo),
        .hsync_o(hsync_o), .hblank_o(hblank_o), .display_enable_out_o(display_enable_out_o),
        .line_advance_o(line_advance_o), .line_pulse_o(line_pulse_o), .hcount_o(hcount_o));
    htiming_host i_host (.clk_sys_i(clk_sys_i), .io_addr_o(io_addr_i), .io_wr_o(io_wr_i),
        .io_rd_o(io_rd_i), .io_wdata_o(io_wdata_i), .io_rdata_i(io_rdata_o));
    // 125 mhz clock and hang guard
    always #4 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 80000) begin
            errors++;
            stop_test();
        end
    end
    // counts vertical step pulses, one cycle each
    always @(negedge clk_sys_i) begin
        if (line_advance_o === 1'b1) adv_seen++;
    end
    // shift register random source
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction : rnd
    // expected clocks for a number of characters
    function automatic int chars(input int n, input logic dot);
        return n * (dot ? 8 : 9);
    endfunction : chars
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic cw(input logic [7:0] idx, input logic [7:0] d);
        i_host.wr(ip(), idx);
        i_host.wr(dp(), d);
    endtask : cw
    task automatic cr(input logic [7:0] idx, output logic [7:0] d);
        i_host.wr(ip(), idx);
        i_host.rd(dp(), d);
    endtask : cr
    // one line: period, high counts and first rise of enable and sync
    task automatic measure(output int p, de, hs, hb, dr, hr);
        int n;
        p = 0; de = 0; hs = 0; hb = 0; dr = -1; hr = -1;
        for (n = 0; n < 3000 && line_pulse_o !== 1'b1; n++) @(negedge clk_sys_i);
        do begin
            @(negedge clk_sys_i);
            p++;
            if (display_enable_out_o === 1'b1 && dr < 0 && de == 0) dr = p;
            if (hsync_o === 1'b1 && hr < 0 && hs == 0) hr = p;
            de += (display_enable_out_o === 1'b1);
            hs += (hsync_o === 1'b1);
            hb += (hblank_o === 1'b1);
        end while (line_pulse_o !== 1'b1 && p < 3000);
    endtask : measure
    task automatic line_case(input logic [7:0] t, d, b, s, input logic [5:0] be,
        input logic [4:0] se, input logic dot);
        logic [7:0] rv [6];
        int i, k, p, de, hs, hb, dr, hr, dr0, hr0, a0;
        rv = '{t, d, b, {1'b1, 2'b00, be[4:0]}, s, {be[5], 2'b00, se}};
        dot_select_i = dot;
        for (i = 0; i < 6; i++) cw(8'(i), rv[i]);
        measure(p, de, hs, hb, dr0, hr0);
        a0 = adv_seen;
        measure(p, de, hs, hb, dr0, hr0);
        check("line_advance", 16'(adv_seen - a0), 16'h0001);
        check("line_period", 16'(p), 16'(chars(t + 5, dot)));
        check("enable_width", 16'(de), 16'(chars(d + 1, dot)));
        check("blank_width", 16'(hb), 16'(chars(6'(be - b[5:0]), dot)));
        check("sync_width", 16'(hs), 16'(chars(5'(se - s[4:0]), dot)));
        k = rnd() % 4;
        cw(IDX_BLANK_END, {1'b1, 2'(k), be[4:0]});
        cw(IDX_SYNC_END, {be[5], 2'(k), se});
        measure(p, de, hs, hb, dr, hr);
        measure(p, de, hs, hb, dr, hr);
        check("enable_skew", 16'(dr), 16'(dr0 + chars(k, dot)));
        check("sync_delay", 16'(hr), 16'(hr0 + chars(k, dot)));
    endtask : line_case
    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : stop_test
    // main sequence
    initial begin
        logic [7:0] r, v, t;
        int k, p, de, hs, hb, dr, hr, bad;
        repeat (10) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        rstn_i = 1'b1;
        for (k = 0; k < 2; k++) begin
            addr_select_i = k[0];
            v = rnd();
            cw({2'b11, IDX_DISP_END}, v);
            i_host.wr(k ? MONO_INDEX_PORT : COLOR_INDEX_PORT, 8'(rnd()));
            i_host.rd(ip(), r);
            check("index", r, {2'b00, IDX_DISP_END});
            cr(IDX_DISP_END, r);
            check("disp_end", r, v);
            i_host.rd(k ? MONO_DATA_PORT : COLOR_DATA_PORT, r);
            check("other_range", r, 8'h00);
        end
        cw(IDX_TOTAL, 8'h14);
        for (k = 1; k < 4; k++) begin
            {group0_protect_i, extension_protect_i} = 2'(k);
            cw(IDX_TOTAL, rnd());
            {group0_protect_i, extension_protect_i} = 2'b00;
            cr(IDX_TOTAL, r);
            check("protected", r, 8'h14);
        end
        for (k = 0; k < 2; k++) begin
            {vs_hi, vs_lo, pen_hi, pen_lo} = rnd();
            cw(IDX_BLANK_END, {k[0], 7'h00});
            cr(IDX_PEN_HIGH, r);
            check("pen_high", r, k ? vs_hi : pen_hi);
            cr(IDX_PEN_LOW, r);
            check("pen_low", r, k ? vs_lo : pen_lo);
        end
        v = rnd();
        t = 8'd20 + v[2:0];
        r = 8'd10 + v[4:3];
        line_case(t, r - 8'd2, r, r + 8'd1, 6'(r + 8'd6), 5'(r + 8'd4 + v[5]), v[6]);
        line_case(8'd60, 8'd31, 8'd40, 8'd44, 6'd46, 5'd17, ~v[6]);
        t = rnd() % 16;
        cw(IDX_ALT_BASE, t);
        alt_mode_i = 1'b1;
        measure(p, de, hs, hb, dr, hr);
        measure(p, de, hs, hb, dr, hr);
        check("alt_period", 16'(p), 16'(chars(t + 5, dot_select_i)));
        alt_mode_i = 1'b0;
        i_host.wr(SEQ_INDEX_PORT, 8'h07);
        i_host.wr(SEQ_DATA_PORT, rnd());
        bad = 0;
        @(negedge clk_sys_i); // hold reaches the counter one clock after the write
        repeat (200) begin
            @(negedge clk_sys_i);
            bad += (hcount_o !== 9'h000 || line_pulse_o !== 1'b0 || line_advance_o !== 1'b0);
        end
        check("held", 16'(bad), 16'h0000);
        i_host.wr(SEQ_INDEX_PORT, 8'(rnd() % 7));
        i_host.wr(SEQ_DATA_PORT, rnd());
        measure(p, de, hs, hb, dr, hr);
        measure(p, de, hs, hb, dr, hr);
        check("released", 16'(p), 16'(chars(65, dot_select_i)));
        stop_test();
    end
endmodule : test_htiming
